/* File: bench/ssc_dev_model.sv */
`timescale 1ns/100ps
module ssc_dev_model #(
  parameter logic [6:0]  DEV_ADDR = 7'h2A,
  parameter logic [63:0] PRE [5]  = '{64'h0, 64'h0010_0000, 64'h0020_0000, 64'h0100, 64'h2000}
) (
  input  wire logic        smp_clk_i,
  input  wire logic        i2c_mode_i,
  input  wire logic        pin0_i,
  input  wire logic        pin1_i,
  input  wire logic        pin2_i,
  output logic             pull_o,
  output logic      [5:0]  bits_o,
  output logic      [63:0] freq_o,
  output logic      [63:0] regs_o [5]
);
  logic [39:0] sh;
  logic [5:0]  cnt;
  logic [3:0]  nbit;
  logic [2:0]  nbyte;
  logic        live, p0, p1, p2;

  // Factory presets; channel starts at zero
  initial
  begin
    regs_o = PRE;
    {sh, cnt, nbit, nbyte, live, pull_o, bits_o, freq_o} = '0;
    {p0, p1, p2} = 3'h7;
  end

  // Scale and route one complete word
  task automatic commit(input logic [31:0] w);
    logic [63:0] v;
    begin
      v = {40'h00_0000_0000, w[23:0]};
      for (int k = 0; k < w[27:24]; k++)
        v = v * 64'h000A;
      if (w[31:28] <= 4'h4)
        regs_o[w[31:28]] = v;
      if (w[31:28] == 4'h0)
        freq_o = regs_o[1] + v * regs_o[3];
    end
  endtask

  // Lines sampled mid-cycle so that all three have settled
  always @(negedge smp_clk_i)
  begin
    if (!i2c_mode_i)
    begin
      if (!p2 && pin2_i && !pin0_i)
        {sh, cnt} = {sh[38:0], pin1_i, cnt + 6'h01};
      if (p0 && !pin0_i)
        cnt = 6'h00;
      if (!p0 && pin0_i)
        bits_o = cnt;
      if (!p0 && pin0_i && cnt == 6'h20)
        commit(sh[31:0]);
    end
    else if (p1 && pin1_i && p0 && !pin0_i)
      {live, nbit, nbyte, pull_o} = {1'b1, 8'h00};
    else if (p1 && pin1_i && !p0 && pin0_i)
    begin
      if (live && nbyte == 3'h5)
        commit(sh[31:0]);
      live = 1'b0;
    end
    else if (live && !p1 && pin1_i && !pull_o && nbyte < 3'h5)
      {sh, nbit} = {sh[38:0], pin0_i, nbit + 4'h1};
    else if (live && p1 && !pin1_i)
    begin
      if (pull_o)
        pull_o = 1'b0;
      else if (nbit == 4'h8 && nbyte == 3'h0 && sh[7:0] != {DEV_ADDR, 1'b0})
        live = 1'b0;
      else if (nbit == 4'h8 && nbyte < 3'h5)
        {pull_o, nbit, nbyte} = {1'b1, 4'h0, nbyte + 3'h1};
    end
    {p0, p1, p2} = {pin0_i, pin1_i, pin2_i};
  end
endmodule

/* File: bench/synth_serial_command_port_tb_top.sv */
`timescale 1ns/100ps
module synth_serial_command_port_tb_top;
  logic        clk_i, rst_b_i, avs_read, avs_write, avs_waitrequest_o;
  logic [3:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata_o;
  logic        p0_o, p0_oe, p1_o, p1_oe, p2_o, p2_oe, dev_pull, tb_mode;
  logic        sda_line, scl_line, clk_line;
  logic [5:0]  dev_bits;
  logic [63:0] dev_freq, exp_freq;
  logic [63:0] dev_regs [5];
  logic [63:0] exp_regs [5];
  int          bad_count, compares;

  // SDA and SCL lines with pull-ups, clock line pulled low; device may pull data low
  assign sda_line = (p0_oe ? p0_o : 1'b1) & ~dev_pull;
  assign scl_line = p1_oe ? p1_o : 1'b1;
  assign clk_line = p2_oe ? p2_o : 1'b0;

  // Controller under test
  ssc_host #(.SPI_HALF(2), .I2C_HALF(8), .TICK_W(9)) DUT (
    .clk_i                             (clk_i),
    .rst_b_i                           (rst_b_i),
    .avs_address_i                     (avs_address),
    .avs_read_i                        (avs_read),
    .avs_write_i                       (avs_write),
    .avs_writedata_i                   (avs_writedata),
    .avs_readdata_o                    (avs_readdata_o),
    .avs_waitrequest_o                 (avs_waitrequest_o),
    .serial_pin_select_or_sda_i        (sda_line),
    .serial_pin_select_or_sda_o        (p0_o),
    .serial_pin_select_or_sda_oe_o     (p0_oe),
    .serial_pin_data_or_scl_i          (scl_line),
    .serial_pin_data_or_scl_o          (p1_o),
    .serial_pin_data_or_scl_oe_o       (p1_oe),
    .serial_pin_clock_or_mode_tie_o    (p2_o),
    .serial_pin_clock_or_mode_tie_oe_o (p2_oe)
  );

  // Synthesizer model on the far side
  ssc_dev_model DEV (
    .smp_clk_i  (clk_i),
    .i2c_mode_i (tb_mode),
    .pin0_i     (sda_line),
    .pin1_i     (scl_line),
    .pin2_i     (clk_line),
    .pull_o     (dev_pull),
    .bits_o     (dev_bits),
    .freq_o     (dev_freq),
    .regs_o     (dev_regs)
  );

  // Clock
  initial
  begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  task automatic end_sim;
    if (bad_count == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic cmp(input logic [63:0] got, input logic [63:0] want, input string m);
    compares++;
    if (got !== want)
    begin
      bad_count++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask

  // One bus access, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    begin
      @(posedge clk_i);
      {avs_address, avs_writedata, avs_write, avs_read} <= {a, d, wr, !wr};
      @(posedge clk_i);
      for (n = 0; n < 50 && avs_waitrequest_o !== 1'b0; n++)
        @(posedge clk_i);
      q = avs_readdata_o;
      {avs_write, avs_read} <= 2'h0;
      cmp(64'(n < 50), 64'h1, "bus stall");
    end
  endtask

  function automatic logic [63:0] scale(input logic [31:0] w);
    logic [63:0] v;
    v = {40'h00_0000_0000, w[23:0]};
    repeat (w[27:24]) v = v * 64'h000A;
    return v;
  endfunction

  // Load mode, address and word, then start a frame
  task automatic start(input logic i2c, input logic [6:0] adr, input logic [31:0] w);
    logic [31:0] q;
    begin
      tb_mode <= i2c;
      bus(1'b1, ssc_pkg::OFF_CTRL, {31'h0000_0000, i2c}, q);
      bus(1'b1, ssc_pkg::OFF_ADDR, {25'h000_0000, adr}, q);
      bus(1'b1, ssc_pkg::OFF_CMD, w, q);
      bus(1'b1, ssc_pkg::OFF_CTRL, {30'h0000_0000, 1'b1, i2c}, q);
    end
  endtask

  // Wait for the frame, then judge flags and every device register
  task automatic finish(input logic i2c, input logic [31:0] w, input logic acked);
    logic [31:0] q;
    begin
      q = 32'h0000_0000;
      for (int n = 0; n < 3000 && q[ssc_pkg::STAT_DONE_BIT] !== 1'b1; n++)
        bus(1'b0, ssc_pkg::OFF_STAT, 32'h0000_0000, q);
      cmp(64'(q[ssc_pkg::STAT_DONE_BIT]), 64'h1, "frame not done");
      cmp(64'(q[ssc_pkg::STAT_NACK_BIT]), 64'(!acked), "ack outcome");
      bus(1'b1, ssc_pkg::OFF_STAT, 32'h0000_0006, q);
      if (acked && w[31:28] <= 4'h4)
        exp_regs[w[31:28]] = scale(w);
      if (acked && w[31:28] == 4'h0)
        exp_freq = exp_regs[1] + exp_regs[0] * exp_regs[3];
      for (int k = 0; k < 5; k++)
        cmp(dev_regs[k], exp_regs[k], "device register");
      cmp(dev_freq, exp_freq, "frequency");
      if (!i2c)
        cmp(64'(dev_bits), 64'h20, "word length");
    end
  endtask

  // Idle pins and register defaults, unmapped places included
  task automatic t_reset;
    logic [31:0] q;
    begin
      exp_regs = dev_regs;
      exp_freq = 64'h0;
      cmp(64'({sda_line, clk_line}), 64'h2, "idle pins");
      bus(1'b1, 4'h6, 32'hFFFF_FFFF, q);
      for (int a = 0; a < 16; a += 2)
      begin
        bus(1'b0, 4'(a), 32'h0000_0000, q);
        cmp(64'(q), 64'h0, "reset value");
      end
    end
  endtask

  // Every select code, boundary value, large multiplier, reserved codes
  task automatic t_spi;
    logic [31:0] w [8];
    begin
      w = '{32'h1300_06A4, 32'h3200_0019, 32'h20FF_FFFF, 32'h4600_0014,
            32'h0000_0007, 32'h0900_0001, 32'h5100_0001, 32'hF000_0003};
      for (int i = 0; i < 8; i++)
      begin
        start(1'b0, 7'h00, w[i]);
        finish(1'b0, w[i], 1'b1);
      end
    end
  endtask

  // Two-wire strings to own and to a foreign address
  task automatic t_i2c;
    begin
      start(1'b1, 7'h2A, 32'h1200_1234);
      finish(1'b1, 32'h1200_1234, 1'b1);
      start(1'b1, 7'h2A, 32'h0000_0003);
      finish(1'b1, 32'h0000_0003, 1'b1);
      start(1'b1, 7'h2B, 32'h3100_0005);
      finish(1'b1, 32'h3100_0005, 1'b0);
    end
  endtask

  // Main sequence
  initial
  begin
    {avs_address, avs_writedata, avs_read, avs_write, rst_b_i, tb_mode} = '0;
    bad_count = 0;
    compares = 0;
    repeat (20) @(posedge clk_i);
    rst_b_i <= 1'b1;
    t_reset;
    t_spi;
    t_i2c;
    end_sim;
  end

  // Watchdog
  initial
  begin
    repeat (60000) @(posedge clk_i);
    bad_count++;
    end_sim;
  end
endmodule

/* File: include/ssc_pkg.sv */
package ssc_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_NS       = 25;
  localparam int SPI_HALF_NS  = 250;
  localparam int I2C_HALF_NS  = 5000;
  localparam int SPI_HALF_CYC = (SPI_HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam int I2C_HALF_CYC = (I2C_HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam int TICK_W       = 9;

  // ****************************************
  // Register map and fields
  // ****************************************
  localparam logic [3:0] OFF_CTRL = 4'h0;
  localparam logic [3:0] OFF_CMD  = 4'h4;
  localparam logic [3:0] OFF_ADDR = 4'h8;
  localparam logic [3:0] OFF_STAT = 4'hC;
  localparam int CTRL_I2C_BIT  = 0;
  localparam int CTRL_GO_BIT   = 1;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam int STAT_NACK_BIT = 2;
  localparam logic        MODE_RST = 1'b0;
  localparam logic [31:0] CMD_RST  = 32'h0000_0000;
  localparam logic [6:0]  ADDR_RST = 7'h00;

  // ****************************************
  // Frame counts
  // ****************************************
  localparam logic [5:0] SPI_LAST_BIT = 6'h1F;
  localparam logic [5:0] I2C_LAST_BIT = 6'h27;
  localparam logic [5:0] SPI_EDGES    = 6'h20;
  localparam logic [5:0] I2C_EDGES    = 6'h2D;
  localparam logic [2:0] BYTE_LAST    = 3'h7;

  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic [3:0]  fsel;
    logic [3:0]  mult;
    logic [23:0] value;
  } ssc_cmd_t;

  typedef enum logic [2:0] {
    ST_IDLE      = 3'h0,
    ST_I2C_START = 3'h1,
    ST_I2C_BIT   = 3'h3,
    ST_I2C_ACK   = 3'h2,
    ST_I2C_STOP  = 3'h6,
    ST_SPI_SHIFT = 3'h7,
    ST_SPI_END   = 3'h5,
    ST_FINISH    = 3'h4
  } ssc_state_t;

endpackage

/* File: src/ssc_host.sv */
// How it works
// [R1] Three-wire command is one 32-bit word
// [R2] Two-wire command is address byte plus word
// [R3] Untouched device registers keep factory presets
// [R4] Channel write sets start plus channel times step
// [R5] Device samples data on rising serial clock
// [R6] Chip select stays low for whole word
// [R7] Chip select rises after 32 bits, latches word
// [R8] Function select field picks the target register
// [R9] Mode pin tied low selects two-wire mode
// [R10] Device only acknowledges, never drives data
// [R11] Device ignores strings for other addresses
// [R12] Address byte direction bit always zero
// [R13] START then exactly five bytes
// [R14] Device acknowledges each of five bytes
// [R15] Command commits only on STOP after byte five
// [R16] START before STOP discards the partial string
// [R17] No repeated START; STOP before next START
// [R18] Select and multiplier share first data byte
// [R19] Low 24 bits are an unsigned value
// [R20] Value scaled by ten to multiplier power
// [R21] Select codes: channel, start, stop, step, reference
// [R22] Word sent most significant bit first
// [R23] Reserved select codes change no register
`timescale 1ns/100ps
module ssc_host #(
  parameter int SPI_HALF = ssc_pkg::SPI_HALF_CYC,
  parameter int I2C_HALF = ssc_pkg::I2C_HALF_CYC,
  parameter int TICK_W   = ssc_pkg::TICK_W
) (
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  input  wire logic [3:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  input  wire logic        serial_pin_select_or_sda_i,
  output logic             serial_pin_select_or_sda_o,
  output logic             serial_pin_select_or_sda_oe_o,
  input  wire logic        serial_pin_data_or_scl_i,
  output logic             serial_pin_data_or_scl_o,
  output logic             serial_pin_data_or_scl_oe_o,
  output logic             serial_pin_clock_or_mode_tie_o,
  output logic             serial_pin_clock_or_mode_tie_oe_o
);

  // ****************************************
  // Declarations
  // ****************************************
  localparam int DONE_WAIT = 2 * SPI_HALF + 4;

  ssc_pkg::ssc_cmd_t   cmd;
  ssc_pkg::ssc_state_t state;
  logic [31:0]         cmd_bits;
  logic [31:0]         rd_mux;
  logic [6:0]          slave_addr;
  logic [39:0]         frame;
  logic [5:0]          bit_cnt;
  logic [2:0]          dec;
  logic [TICK_W-1:0]   half_lim;
  logic                mode_i2c;
  logic                go;
  logic                done;
  logic                nack;
  logic                access;
  logic                busy;
  logic                mode_act;
  logic                pin_i2c;
  logic                frame_nack;
  logic                set_done;
  logic                set_nack;
  logic                lvl_sel;
  logic                lvl_dat;
  logic                lvl_clk;
  logic                sda_s1;
  logic                sda_s2;
  logic                scl_s1;
  logic                scl_s2;
  logic                tick;
  logic                hold;

  generate
    if (SPI_HALF < 1 || I2C_HALF < 1 || SPI_HALF >= 2**TICK_W || I2C_HALF >= 2**TICK_W)
    begin : g_bad_half
      $error("ssc_host half period does not fit the divider");
    end
  endgenerate

  // Address decode: hit flag and word index
  function automatic logic [2:0] reg_sel(input logic [3:0] a);
    reg_sel = {a[1:0] == 2'h0, a[3:2]};
  endfunction

  assign cmd_bits = cmd;
  assign dec      = reg_sel(avs_address_i);
  assign access   = (avs_read_i || avs_write_i) && !avs_waitrequest_o;

  // ****************************************
  // Register bus slave
  // ****************************************

  // Read mux, unmapped reads as zero
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (dec[2])
    begin
      unique case (dec[1:0])
        2'h0: rd_mux[ssc_pkg::CTRL_I2C_BIT] = mode_i2c;
        2'h1: rd_mux = cmd_bits;
        2'h2: rd_mux[6:0] = slave_addr;
        2'h3:
        begin
          rd_mux[ssc_pkg::STAT_BUSY_BIT] = busy | go;
          rd_mux[ssc_pkg::STAT_DONE_BIT] = done;
          rd_mux[ssc_pkg::STAT_NACK_BIT] = nack;
        end
      endcase
    end
  end

  // One wait cycle, then answer
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o    <= 32'h0000_0000;
    end
    else if ((avs_read_i || avs_write_i) && avs_waitrequest_o)
    begin
      avs_waitrequest_o <= 1'b0;
      avs_readdata_o    <= avs_read_i ? rd_mux : 32'h0000_0000;
    end
    else
    begin
      avs_waitrequest_o <= 1'b1;
    end
  end

  // Setup registers, locked while a frame runs
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      mode_i2c   <= ssc_pkg::MODE_RST;
      cmd        <= ssc_pkg::CMD_RST;
      slave_addr <= ssc_pkg::ADDR_RST;
      go         <= 1'b0;
    end
    else
    begin
      go <= access && avs_write_i && dec == {1'b1, ssc_pkg::OFF_CTRL[3:2]}
            && avs_writedata_i[ssc_pkg::CTRL_GO_BIT] && !busy && !go;
      if (access && avs_write_i && dec[2] && !busy && !go)
      begin
        unique case (dec[1:0])
          2'h0: mode_i2c <= avs_writedata_i[ssc_pkg::CTRL_I2C_BIT];
          2'h1: cmd <= avs_writedata_i;
          2'h2: slave_addr <= avs_writedata_i[6:0];
          2'h3: ;
        endcase
      end
    end
  end

  // Sticky status, set beats clear
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      done <= 1'b0;
      nack <= 1'b0;
    end
    else
    begin
      done <= set_done | (done & ~(access && avs_write_i && dec == 3'h7
              && avs_writedata_i[ssc_pkg::STAT_DONE_BIT]));
      nack <= set_nack | (nack & ~(access && avs_write_i && dec == 3'h7
              && avs_writedata_i[ssc_pkg::STAT_NACK_BIT]));
    end
  end

  // ****************************************
  // Line timing
  // ****************************************

  // Two-stage synchronisers for the open-drain lines
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
    end
    else
    begin
      sda_s1 <= serial_pin_select_or_sda_i;
      sda_s2 <= sda_s1;
      scl_s1 <= serial_pin_data_or_scl_i;
      scl_s2 <= scl_s1;
    end
  end

  // Released clock held low by the far side stretches the phase
  assign hold     = mode_act && lvl_dat && !scl_s2;
  assign half_lim = mode_act ? TICK_W'(I2C_HALF) : TICK_W'(SPI_HALF);

  ssc_tick #(
    .W (TICK_W)
  ) u_tick (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .run_i   (busy),
    .hold_i  (hold),
    .limit_i (half_lim),
    .tick_o  (tick)
  );

  // ****************************************
  // Frame engine
  // ****************************************
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      state      <= ssc_pkg::ST_IDLE;
      busy       <= 1'b0;
      mode_act   <= ssc_pkg::MODE_RST;
      frame      <= '0;
      bit_cnt    <= '0;
      frame_nack <= 1'b0;
      set_done   <= 1'b0;
      set_nack   <= 1'b0;
      lvl_sel    <= 1'b1;
      lvl_dat    <= 1'b0;
      lvl_clk    <= 1'b0;
    end
    else
    begin
      set_done <= 1'b0;
      set_nack <= 1'b0;
      unique case (state)
        ssc_pkg::ST_IDLE:
        begin
          mode_act <= mode_i2c;
          lvl_sel  <= 1'b1;
          lvl_dat  <= mode_i2c;
          lvl_clk  <= 1'b0;
          bit_cnt  <= '0;
          if (go)
          begin
            busy       <= 1'b1;
            frame_nack <= 1'b0;
            lvl_sel    <= 1'b0; // R6 R13
            if (mode_i2c)
            begin
              frame <= {slave_addr, 1'b0, cmd}; // R2 R12 R18
              state <= ssc_pkg::ST_I2C_START; // R17
            end
            else
            begin
              frame   <= {cmd, 8'h00}; // R1
              lvl_dat <= cmd_bits[31]; // R22
              state   <= ssc_pkg::ST_SPI_SHIFT;
            end
          end
        end
        ssc_pkg::ST_SPI_SHIFT:
        begin
          if (tick && !lvl_clk)
          begin
            lvl_clk <= 1'b1;
          end
          else if (tick)
          begin
            lvl_clk <= 1'b0;
            if (bit_cnt == ssc_pkg::SPI_LAST_BIT) // R1
            begin
              state <= ssc_pkg::ST_SPI_END;
            end
            else
            begin
              frame   <= {frame[38:0], 1'b0}; // R22
              lvl_dat <= frame[38];
              bit_cnt <= bit_cnt + 6'h01;
            end
          end
        end
        ssc_pkg::ST_SPI_END:
        begin
          if (tick)
          begin
            lvl_sel <= 1'b1; // R7
            state   <= ssc_pkg::ST_FINISH;
          end
        end
        ssc_pkg::ST_I2C_START:
        begin
          if (tick)
          begin
            lvl_dat <= 1'b0;
            lvl_sel <= frame[39]; // R22
            state   <= ssc_pkg::ST_I2C_BIT;
          end
        end
        ssc_pkg::ST_I2C_BIT:
        begin
          if (tick && !lvl_dat)
          begin
            lvl_dat <= 1'b1;
          end
          else if (tick)
          begin
            lvl_dat <= 1'b0;
            if (bit_cnt[2:0] == ssc_pkg::BYTE_LAST)
            begin
              lvl_sel <= 1'b1; // R14
              state   <= ssc_pkg::ST_I2C_ACK;
            end
            else
            begin
              frame   <= {frame[38:0], 1'b0};
              lvl_sel <= frame[38];
              bit_cnt <= bit_cnt + 6'h01;
            end
          end
        end
        ssc_pkg::ST_I2C_ACK:
        begin
          if (tick && !lvl_dat)
          begin
            lvl_dat <= 1'b1;
          end
          else if (tick)
          begin
            lvl_dat <= 1'b0;
            if (sda_s2 || bit_cnt == ssc_pkg::I2C_LAST_BIT) // R13 R16
            begin
              frame_nack <= sda_s2;
              set_nack   <= sda_s2;
              lvl_sel    <= 1'b0;
              state      <= ssc_pkg::ST_I2C_STOP;
            end
            else
            begin
              frame   <= {frame[38:0], 1'b0};
              lvl_sel <= frame[38];
              bit_cnt <= bit_cnt + 6'h01;
              state   <= ssc_pkg::ST_I2C_BIT;
            end
          end
        end
        ssc_pkg::ST_I2C_STOP:
        begin
          if (tick && !lvl_dat)
          begin
            lvl_dat <= 1'b1;
          end
          else if (tick)
          begin
            lvl_sel <= 1'b1; // R15 R17
            state   <= ssc_pkg::ST_FINISH;
          end
        end
        ssc_pkg::ST_FINISH:
        begin
          if (tick)
          begin
            busy     <= 1'b0;
            set_done <= 1'b1;
            state    <= ssc_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  // ****************************************
  // Pin drivers
  // ****************************************

  // Open drain on data and clock in two-wire mode, push-pull otherwise and for the mode tie
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      pin_i2c                           <= ssc_pkg::MODE_RST;
      serial_pin_select_or_sda_o        <= 1'b1;
      serial_pin_select_or_sda_oe_o     <= 1'b1;
      serial_pin_data_or_scl_o          <= 1'b0;
      serial_pin_data_or_scl_oe_o       <= 1'b1;
      serial_pin_clock_or_mode_tie_o    <= 1'b0;
      serial_pin_clock_or_mode_tie_oe_o <= 1'b1;
    end
    else
    begin
      pin_i2c                           <= mode_act;
      serial_pin_select_or_sda_o        <= mode_act ? 1'b0 : lvl_sel;
      serial_pin_select_or_sda_oe_o     <= mode_act ? !lvl_sel : 1'b1;
      serial_pin_data_or_scl_o          <= mode_act ? 1'b0 : lvl_dat;
      serial_pin_data_or_scl_oe_o       <= mode_act ? !lvl_dat : 1'b1;
      serial_pin_clock_or_mode_tie_o    <= mode_act ? 1'b0 : lvl_clk; // R9
      serial_pin_clock_or_mode_tie_oe_o <= 1'b1;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  logic [5:0] spi_edges;
  logic [5:0] i2c_edges;
  logic       p0_q;
  logic       p2_q;
  logic       p0oe_q;
  logic       p1oe_q;
  logic       spi_clk_up;
  logic       i2c_start;
  logic       i2c_stop;
  logic       scl_up;

  assign spi_clk_up = !pin_i2c && serial_pin_clock_or_mode_tie_o && !p2_q;
  assign scl_up     = pin_i2c && !serial_pin_data_or_scl_oe_o && p1oe_q;
  assign i2c_start  = pin_i2c && serial_pin_select_or_sda_oe_o && !p0oe_q
                      && !serial_pin_data_or_scl_oe_o;
  assign i2c_stop   = pin_i2c && !serial_pin_select_or_sda_oe_o && p0oe_q
                      && !serial_pin_data_or_scl_oe_o && !p1oe_q;

  // Edge counters seen at the pins
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      spi_edges <= '0;
      i2c_edges <= '0;
      p0_q      <= 1'b1;
      p2_q      <= 1'b0;
      p0oe_q    <= 1'b1;
      p1oe_q    <= 1'b1;
    end
    else
    begin
      p0_q   <= serial_pin_select_or_sda_o;
      p2_q   <= serial_pin_clock_or_mode_tie_o;
      p0oe_q <= serial_pin_select_or_sda_oe_o;
      p1oe_q <= serial_pin_data_or_scl_oe_o;
      if (!pin_i2c && !serial_pin_select_or_sda_o && p0_q)
        spi_edges <= '0;
      else if (spi_clk_up)
        spi_edges <= spi_edges + 6'h01;
      if (i2c_start)
        i2c_edges <= '0;
      else if (scl_up)
        i2c_edges <= i2c_edges + 6'h01;
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);

  chk_spi_word_len: assert property ( // R1
    (!pin_i2c && !$past(pin_i2c) && serial_pin_select_or_sda_o && !p0_q)
    |-> spi_edges == ssc_pkg::SPI_EDGES)
    else $error("serial word not 32 clocks");
  chk_spi_cs_low: assert property ( // R6
    spi_clk_up |-> !serial_pin_select_or_sda_o)
    else $error("clock rose with select high");
  chk_spi_cs_rise: assert property ( // R7
    (!pin_i2c && !$past(pin_i2c) && serial_pin_select_or_sda_o && !p0_q)
    |-> !serial_pin_clock_or_mode_tie_o ##[1:DONE_WAIT] !busy)
    else $error("select rise not at word end");
  chk_spi_msb_first: assert property ( // R22
    spi_clk_up |-> serial_pin_data_or_scl_o == cmd_bits[5'(6'h1F - spi_edges)])
    else $error("serial bit order wrong");
  chk_i2c_mode_tie: assert property ( // R9
    pin_i2c |-> serial_pin_clock_or_mode_tie_oe_o && !serial_pin_clock_or_mode_tie_o)
    else $error("mode pin not held low");
  chk_i2c_rw_zero: assert property ( // R12
    (scl_up && i2c_edges == 6'h07) |-> serial_pin_select_or_sda_oe_o)
    else $error("direction bit not zero");
  chk_i2c_start_only: assert property ( // R13
    i2c_start |-> state == ssc_pkg::ST_I2C_START && $past(state, 2) == ssc_pkg::ST_IDLE)
    else $error("start outside string opening");
  chk_i2c_len: assert property ( // R2
    (i2c_stop && !frame_nack) |-> i2c_edges == ssc_pkg::I2C_EDGES + 6'h01) // STOP rise too
    else $error("string not 40 bits plus acks");
  chk_i2c_stop_end: assert property ( // R15
    i2c_stop |-> state == ssc_pkg::ST_FINISH ##1 !i2c_start [*4])
    else $error("stop not closing the string");
  chk_i2c_no_restart: assert property ( // R17
    (pin_i2c && state == ssc_pkg::ST_I2C_BIT) |-> !i2c_start)
    else $error("repeated start inside string");
  chk_bus_answer: assert property (
    ((avs_read_i || avs_write_i) && avs_waitrequest_o) |=> !avs_waitrequest_o)
    else $error("bus answer late");

  cov_spi_word: cover property (
    !pin_i2c && !$past(pin_i2c) && serial_pin_select_or_sda_o && !p0_q);
  cov_i2c_ok: cover property (i2c_stop && !frame_nack);
  cov_i2c_nack: cover property (i2c_stop && frame_nack);

endmodule

/* File: src/ssc_tick.sv */
`timescale 1ns/100ps
module ssc_tick #(
  parameter int W = 9
) (
  input  wire logic         clk_i,
  input  wire logic         rst_b_i,
  input  wire logic         run_i,
  input  wire logic         hold_i,
  input  wire logic [W-1:0] limit_i,
  output logic              tick_o
);

  logic [W-1:0] cnt;

  generate
    if (W < 2)
    begin : g_bad_width
      $error("ssc_tick width too small");
    end
  endgenerate

  // Half-period divider, frozen while held
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i || !run_i)
    begin
      cnt    <= '0;
      tick_o <= 1'b0;
    end
    else if (hold_i)
    begin
      tick_o <= 1'b0;
    end
    else if (cnt == limit_i - 1'b1)
    begin
      cnt    <= '0;
      tick_o <= 1'b1;
    end
    else
    begin
      cnt    <= cnt + 1'b1;
      tick_o <= 1'b0;
    end
  end

endmodule
